// ### bench/pfm_chk.sv
/* Checker: port 0 outputs against its last config word.
   Assumes bind into pfm_port_mode; frozen cycles are not judged. */
`timescale 1ns/1ps
module pfm_chk
    import pfm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic cfg_wr,
    input wire logic [3:0] cfg_wr_port,
    input wire logic [15:0] cfg_wr_data,
    input wire logic [11:0] output_level_bits,
    input wire logic [11:0] port_input_bits,
    input wire logic [11:0] port_drive_en,
    input wire logic [11:0] port_level,
    input wire logic [11:0] port_analog,
    input wire logic [11:0] port_sample,
    input wire logic [11:0] port_diff,
    input wire logic [143:0] port_dac_code
);
    logic [15:0] cq_reg, cq_next, cd_reg;
    logic [11:0] in1_reg, in2_reg, in3_reg;
    logic [3:0] m;
    logic fwd_src;
    default clocking @(posedge ref_clk); endclocking
    // Frozen cycles say nothing about the mode outputs
    default disable iff (rst || !ce);
    // Word the outputs are built from, two edges behind the write
    always_comb begin
        cq_next = (cfg_wr && cfg_wr_port == 4'h0) ? cfg_wr_data : cq_reg;
    end
    // Word history and pin inputs three edges back, frozen with ce
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cq_reg <= 16'h0000;
            cd_reg <= 16'h0000;
            in1_reg <= 12'h000;
            in2_reg <= 12'h000;
            in3_reg <= 12'h000;
        end else if (ce) begin
            cq_reg <= cq_next;
            cd_reg <= cq_reg;
            in1_reg <= port_input_bits;
            in2_reg <= in1_reg;
            in3_reg <= in2_reg;
        end
    end
    assign m = cd_reg[15:12];
    // Link index past the last port reads as a low source
    assign fwd_src = (cd_reg[3:0] < 4'hc) ? in3_reg[cd_reg[3:0]] : 1'b0;
    property p_off; m == PFM_HIZ |-> !port_drive_en[0]; endproperty
    a_off: assert property (p_off) else $error("driven in mode 0");
    property p_lvl; m == PFM_REG_OUT |-> port_level[0] == $past(output_level_bits[0]); endproperty
    a_lvl: assert property (p_lvl) else $error("mode 3 level wrong");
    property p_fwd; m == PFM_FWD_OUT |-> port_drive_en[0]
        && port_level[0] == (fwd_src ^ cd_reg[11]); endproperty
    a_fwd: assert property (p_fwd) else $error("forwarded level wrong");
    property p_ana; m == PFM_ANA_OUT |-> port_analog[0] && !port_sample[0]; endproperty
    a_ana: assert property (p_ana) else $error("mode 5 flags wrong");
    property p_mon; m == PFM_ANA_MON |-> port_analog[0] && port_sample[0]; endproperty
    a_mon: assert property (p_mon) else $error("mode 6 flags wrong");
    property p_clip; m == PFM_ANA_MON && cd_reg[10] && !cd_reg[8]
        |-> port_dac_code[11:0] <= 12'h7ff; endproperty
    a_clip: assert property (p_clip) else $error("code not clipped");
    property p_se; m == PFM_ADC_SE |-> port_sample[0] && !port_drive_en[0]; endproperty
    a_se: assert property (p_se) else $error("mode 7 flags wrong");
    property p_dif; m == PFM_ADC_DIFF |-> port_diff[0] && port_sample[0]; endproperty
    a_dif: assert property (p_dif) else $error("mode 8 flags wrong");
endmodule : pfm_chk
bind pfm_port_mode pfm_chk chk (.*);

// ### bench/pfm_host.sv
/* Host model: writes whole config and converter words.
   Assumes the block takes a write on the edge its strobe is high. */
`timescale 1ns/1ps
`include "pfm_params.svh"
module pfm_host #(
    parameter int SETTLE = `PFM_SETTLE_CYCLES
) (
    input wire logic ref_clk,
    output logic cfg_wr,
    output logic [3:0] cfg_wr_port,
    output logic [15:0] cfg_wr_data,
    output logic dac_wr,
    output logic [3:0] dac_wr_port,
    output logic [11:0] dac_wr_data
);
    // Idle strobes from time zero
    initial begin
        cfg_wr = 1'b0;
        dac_wr = 1'b0;
    end
    // Released data lines show a changed pattern, not the last word
    task automatic cfg(input logic [3:0] p, input logic [15:0] d);
        @(posedge ref_clk);
        {cfg_wr, cfg_wr_port, cfg_wr_data} <= {1'b1, p, d};
        @(posedge ref_clk);
        {cfg_wr, cfg_wr_data} <= {1'b0, ~d};
    endtask : cfg
    task automatic dac(input logic [3:0] p, input logic [11:0] d);
        @(posedge ref_clk);
        {dac_wr, dac_wr_port, dac_wr_data} <= {1'b1, p, d};
        @(posedge ref_clk);
        {dac_wr, dac_wr_data} <= {1'b0, ~d};
    endtask : dac
    task automatic reg_out(input logic [3:0] p, input logic [11:0] lvl);
        dac(p, lvl);
        repeat (SETTLE) @(posedge ref_clk);
        cfg(p, 16'h3000);
    endtask : reg_out
    task automatic fwd(input logic [3:0] p, input logic [3:0] s, input logic invert_flag);
        cfg(s, 16'h1000);
        cfg(p, {4'h4, invert_flag, 7'h00, s});
    endtask : fwd
endmodule : pfm_host

// ### bench/test_port_function_mode_logic.sv
/* Testbench for pfm_port_mode, checker bound in, host model beside.
   Assumes the clock enable drops only in its own scenario. */
`timescale 1ns/1ps
module test_port_function_mode_logic;
    logic ref_clk = 1'b0, rst = 1'b1, ce = 1'b1, adc_done = 1'b0, cfg_wr, dac_wr;
    logic [3:0] adc_done_port = 4'h0, result_rd_port = 4'h0, cfg_wr_port, dac_wr_port;
    logic [11:0] adc_done_data = 12'h000, output_level_bits = 12'h000;
    logic [11:0] port_input_bits = 12'h000, dac_wr_data, port_drive_en, port_digital;
    logic [11:0] port_level, port_analog, port_sample, port_diff, conversion_reference_select;
    logic [11:0] result_rd_data;
    logic [15:0] cfg_wr_data;
    logic [35:0] port_range, average_count;
    logic [47:0] port_neg_sel;
    logic [143:0] port_dac_code;
    int n_fail = 0, total_checks = 0;
    pfm_port_mode DUT (.*);
    // Full settle wait kept; it dominates the run length
    pfm_host host (.*);
    // Free-running 20 MHz clock
    initial forever #25 ref_clk = ~ref_clk;
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Step past the edge so registered outputs have landed
    task automatic w(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : w
    task automatic complete_run;
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run
    task automatic t_regout;
        host.reg_out(4'h0, 12'habc);
        @(posedge ref_clk) output_level_bits <= 12'h001;
        w(1);
        chk("level hi", 16'h0003, {14'h0, port_drive_en[0], port_level[0]});
        chk("code", 16'h0abc, {4'h0, port_dac_code[11:0]});
        @(posedge ref_clk) output_level_bits <= 12'hffe;
        w(1);
        chk("level lo", 16'h0002, {14'h0, port_drive_en[0], port_level[0]});
    endtask : t_regout
    // Two outputs share one source, one of them inverted
    task automatic t_fwd;
        host.fwd(4'h0, 4'h5, 1'b0);
        host.fwd(4'h1, 4'h5, 1'b1);
        for (int v = 0; v < 2; v++) begin
            @(posedge ref_clk) port_input_bits <= v[0] ? 12'h020 : 12'hfdf;
            w(3);
            chk("fwd", v[0] ? 16'h0001 : 16'h0002, {14'h0, port_level[1:0]});
        end
        chk("fwd en", 16'h0003, {14'h0, port_drive_en[1:0]});
    endtask : t_fwd
    task automatic t_ana;
        host.dac(4'h0, 12'h123);
        host.cfg(4'h0, 16'h5100);
        w(1);
        chk("ana", 16'h1232, {port_dac_code[11:0], 2'h0, port_analog[0], port_sample[0]});
    endtask : t_ana
    // Full-scale code against both low ranges and one wide range
    task automatic t_mon;
        logic [2:0] r;
        host.dac(4'h0, 12'hfff);
        for (int i = 0; i < 3; i++) begin
            r = (i == 2) ? 3'h1 : 3'(4 + 2 * i);
            host.cfg(4'h0, {4'h6, 1'b1, r, 8'h00});
            w(1);
            chk("clip", (i == 2) ? 16'h0fff : 16'h07ff, {4'h0, port_dac_code[11:0]});
            chk("mon", {9'h0, 4'hf, r}, {9'h0, port_analog[0], port_sample[0], port_drive_en[0],
                conversion_reference_select[0], port_range[2:0]});
        end
        // In-range code loaded before the low range is chosen
        host.dac(4'h0, 12'h400);
        host.cfg(4'h0, 16'h6c00);
        w(1);
        chk("in range", 16'h0400, {4'h0, port_dac_code[11:0]});
    endtask : t_mon
    // Results kept for the monitored port, not for the forwarding one
    task automatic t_res;
        @(posedge ref_clk) {adc_done, adc_done_port, adc_done_data} <= {1'b1, 4'h0, 12'h5a5};
        @(posedge ref_clk) {adc_done_port, adc_done_data} <= {4'h1, 12'h3c3};
        @(posedge ref_clk) adc_done <= 1'b0;
        w(2);
        chk("result 0", 16'h05a5, {4'h0, result_rd_data});
        @(posedge ref_clk) result_rd_port <= 4'h1;
        w(2);
        chk("result 1", 16'h0000, {4'h0, result_rd_data});
    endtask : t_res
    task automatic t_adc;
        host.cfg(4'h0, 16'h71a0);
        w(1);
        chk("single", 16'h0015, {11'h0, port_sample[0], port_drive_en[0], average_count[2:0]});
        host.cfg(4'h0, 16'h81a9);
        w(1);
        chk("diff", 16'h0039, {10'h0, port_diff[0], port_sample[0], port_neg_sel[3:0]});
    endtask : t_adc
    // Index above the last port must not land anywhere
    task automatic t_bad;
        host.cfg(4'hc, 16'h3000);
        w(1);
        chk("bad port", 16'h0002, {4'h0, port_drive_en});
    endtask : t_bad
    // A write while frozen is lost and the old mode stays
    task automatic t_ce;
        @(posedge ref_clk) ce <= 1'b0;
        host.cfg(4'h1, 16'h0000);
        w(2);
        chk("frozen", 16'h0001, {15'h0, port_drive_en[1]});
        @(posedge ref_clk) ce <= 1'b1;
        w(2);
        chk("kept", 16'h0001, {15'h0, port_drive_en[1]});
        host.cfg(4'h1, 16'h0000);
        w(1);
        chk("hi-z", 16'h0000, {14'h0, port_drive_en[1], port_digital[1]});
    endtask : t_ce
    // Main sequence
    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        chk("reset", 16'h0000, {4'h0, port_drive_en});
        t_regout;
        t_fwd;
        t_ana;
        t_mon;
        t_res;
        t_adc;
        t_bad;
        t_ce;
        complete_run;
    end
    // Hang guard, about twice the settle-dominated run
    initial begin
        #2000000;
        n_fail++;
        complete_run;
    end
endmodule : test_port_function_mode_logic

// ### core/pfm_params.svh
/*
 * Constants for the port function mode logic: field positions inside a
 * port configuration word, reset values and the settle figure.
 * Assumes it is included by bare name from the package and the design.
 */
`ifndef PFM_PARAMS_SVH
`define PFM_PARAMS_SVH

// Configuration word layout
`define PFM_MODE_MSB 15
`define PFM_MODE_LSB 12
`define PFM_INV_BIT 11
`define PFM_REF_BIT 11
`define PFM_RANGE_MSB 10
`define PFM_RANGE_LSB 8
`define PFM_AVG_MSB 7
`define PFM_AVG_LSB 5
`define PFM_LINK_MSB 3
`define PFM_LINK_LSB 0

// Range codes that select the low monitoring input range
`define PFM_RANGE_LOW_A 3'h4
`define PFM_RANGE_LOW_B 3'h6

// Reset values and the low-range clip code
`define PFM_CFG_RESET 16'h0000
`define PFM_DAC_RESET 12'h000
`define PFM_CLIP_CODE 12'h7ff

// Host settle time for a converter level, in ns, and cycles at 50 ns
`define PFM_SETTLE_NS 1000000
`define PFM_CLK_NS 50
`define PFM_SETTLE_CYCLES (`PFM_SETTLE_NS / `PFM_CLK_NS)

`endif

// ### core/pfm_pkg.sv
/*
 * Types for the port function mode logic: the mode code enumeration.
 * Assumes pfm_params.svh sits beside it.
 */
`include "pfm_params.svh"

package pfm_pkg;

    // Port function codes, four bits wide
    typedef enum logic [3:0] {
        PFM_HIZ = 4'h0,
        PFM_GPI = 4'h1,
        PFM_BIDIR = 4'h2,
        PFM_REG_OUT = 4'h3,
        PFM_FWD_OUT = 4'h4,
        PFM_ANA_OUT = 4'h5,
        PFM_ANA_MON = 4'h6,
        PFM_ADC_SE = 4'h7,
        PFM_ADC_DIFF = 4'h8
    } pfm_mode_type;

endpackage : pfm_pkg

// ### core/pfm_port_mode.sv
/*
 * Port function mode logic for twelve mixed-signal ports: holds each port's
 * configuration and converter data words, routes digital output levels,
 * picks forwarding sources, clips converter codes and stores results.
 * Assumes analog converters, comparators and the serial interface sit
 * outside; port_input_bits arrive from pins and are synchronised here.
 */
// Function
// - Mode 3 drives output_level_bits bit digitally
// - Mode 4 forwards linked input port value
// - Invert flag inverts forwarded value
// - Many outputs may share one source
// - Mode 5 drives analog level from data
// - Mode 6 adds sampling and result storage
// - Mode 6 low range clips data code
// - Mode 6 uses reference and range fields
// - Mode 7 is single-ended converter input
// - Mode 8 is differential positive input
// - Mode code in config bits 15:12
// - Mode 0 leaves the port undriven
`timescale 1ns/1ps
`include "pfm_params.svh"

module pfm_port_mode
    import pfm_pkg::*;
#(
    parameter int NUM_PORTS = 12,
    parameter int DATA_W = 12,
    parameter logic [11:0] CLIP_CODE = `PFM_CLIP_CODE
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic cfg_wr,
    input wire logic [3:0] cfg_wr_port,
    input wire logic [15:0] cfg_wr_data,
    input wire logic dac_wr,
    input wire logic [3:0] dac_wr_port,
    input wire logic [DATA_W-1:0] dac_wr_data,
    input wire logic [NUM_PORTS-1:0] output_level_bits,
    input wire logic [NUM_PORTS-1:0] port_input_bits,
    input wire logic adc_done,
    input wire logic [3:0] adc_done_port,
    input wire logic [DATA_W-1:0] adc_done_data,
    input wire logic [3:0] result_rd_port,
    output logic [DATA_W-1:0] result_rd_data,
    output logic [NUM_PORTS-1:0] port_drive_en,
    output logic [NUM_PORTS-1:0] port_digital,
    output logic [NUM_PORTS-1:0] port_level,
    output logic [NUM_PORTS-1:0] port_analog,
    output logic [NUM_PORTS-1:0] port_sample,
    output logic [NUM_PORTS-1:0] port_diff,
    output logic [NUM_PORTS-1:0] conversion_reference_select,
    output logic [NUM_PORTS*3-1:0] port_range,
    output logic [NUM_PORTS*3-1:0] average_count,
    output logic [NUM_PORTS*4-1:0] port_neg_sel,
    output logic [NUM_PORTS*DATA_W-1:0] port_dac_code
);

    // Stored configuration, converter data and result words
    logic [15:0] cfg_reg [NUM_PORTS];
    logic [15:0] cfg_next [NUM_PORTS];
    logic [DATA_W-1:0] dac_reg [NUM_PORTS];
    logic [DATA_W-1:0] dac_next [NUM_PORTS];
    logic [DATA_W-1:0] res_reg [NUM_PORTS];
    logic [DATA_W-1:0] res_next [NUM_PORTS];
    logic [DATA_W-1:0] rd_reg;
    logic [DATA_W-1:0] rd_next;

    // Pin input synchroniser, two stages
    logic [NUM_PORTS-1:0] in_meta_reg;
    logic [NUM_PORTS-1:0] in_sync_reg;

    // Registered port controls
    logic [NUM_PORTS-1:0] drive_reg, drive_next;
    logic [NUM_PORTS-1:0] dig_reg, dig_next;
    logic [NUM_PORTS-1:0] lvl_reg, lvl_next;
    logic [NUM_PORTS-1:0] ana_reg, ana_next;
    logic [NUM_PORTS-1:0] smp_reg, smp_next;
    logic [NUM_PORTS-1:0] diff_reg, diff_next;
    logic [NUM_PORTS-1:0] ref_reg, ref_next;
    logic [NUM_PORTS*3-1:0] range_reg, range_next;
    logic [NUM_PORTS*3-1:0] avg_reg, avg_next;
    logic [NUM_PORTS*4-1:0] neg_reg, neg_next;
    logic [NUM_PORTS*DATA_W-1:0] code_reg, code_next;

    // Host-side register writes and converter result capture
    always_comb begin
        for (int i = 0; i < NUM_PORTS; i++) begin
            cfg_next[i] = cfg_reg[i];
            dac_next[i] = dac_reg[i];
            res_next[i] = res_reg[i];
            if (cfg_wr && (cfg_wr_port == 4'(i))) begin
                cfg_next[i] = cfg_wr_data;
            end
            if (dac_wr && (dac_wr_port == 4'(i))) begin
                dac_next[i] = dac_wr_data;
            end
            if (adc_done && (adc_done_port == 4'(i))) begin
                case (pfm_mode_type'(cfg_reg[i][`PFM_MODE_MSB:`PFM_MODE_LSB]))
                    PFM_ANA_MON, PFM_ADC_SE, PFM_ADC_DIFF: begin
                        res_next[i] = adc_done_data;
                    end
                    default: begin
                        res_next[i] = res_reg[i];
                    end
                endcase
            end
        end
        rd_next = (result_rd_port < 4'(NUM_PORTS)) ? res_reg[result_rd_port] : '0;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_PORTS; i++) begin
                cfg_reg[i] <= `PFM_CFG_RESET;
                dac_reg[i] <= `PFM_DAC_RESET;
                res_reg[i] <= '0;
            end
            rd_reg <= '0;
        end else if (ce) begin
            for (int i = 0; i < NUM_PORTS; i++) begin
                cfg_reg[i] <= cfg_next[i];
                dac_reg[i] <= dac_next[i];
                res_reg[i] <= res_next[i];
            end
            rd_reg <= rd_next;
        end
    end

    // Two flops before any logic reads the pin inputs
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            in_meta_reg <= '0;
            in_sync_reg <= '0;
        end else if (ce) begin
            in_meta_reg <= port_input_bits;
            in_sync_reg <= in_meta_reg;
        end
    end

    // Per-port decode of mode into drive, level and converter controls
    always_comb begin
        logic [3:0] code;
        logic [3:0] link;
        logic [2:0] rng;
        logic src;
        code = '0;
        link = '0;
        rng = '0;
        src = 1'b0;
        for (int i = 0; i < NUM_PORTS; i++) begin
            code = cfg_reg[i][`PFM_MODE_MSB:`PFM_MODE_LSB];
            link = cfg_reg[i][`PFM_LINK_MSB:`PFM_LINK_LSB];
            rng = cfg_reg[i][`PFM_RANGE_MSB:`PFM_RANGE_LSB];
            // any port may read any source
            src = (link < 4'(NUM_PORTS)) ? in_sync_reg[link] : 1'b0;
            drive_next[i] = 1'b0;
            dig_next[i] = 1'b0;
            lvl_next[i] = 1'b0;
            ana_next[i] = 1'b0;
            smp_next[i] = 1'b0;
            diff_next[i] = 1'b0;
            ref_next[i] = 1'b0;
            range_next[i*3 +: 3] = rng;
            avg_next[i*3 +: 3] = cfg_reg[i][`PFM_AVG_MSB:`PFM_AVG_LSB];
            neg_next[i*4 +: 4] = 4'h0;
            code_next[i*DATA_W +: DATA_W] = dac_reg[i];
            case (pfm_mode_type'(code))
                PFM_REG_OUT: begin
                    drive_next[i] = 1'b1;
                    dig_next[i] = 1'b1;
                    lvl_next[i] = output_level_bits[i];
                end
                PFM_FWD_OUT: begin
                    drive_next[i] = 1'b1;
                    dig_next[i] = 1'b1;
                    lvl_next[i] = src ^ cfg_reg[i][`PFM_INV_BIT];
                end
                PFM_ANA_OUT: begin
                    drive_next[i] = 1'b1;
                    ana_next[i] = 1'b1;
                end
                PFM_ANA_MON: begin
                    drive_next[i] = 1'b1;
                    ana_next[i] = 1'b1;
                    smp_next[i] = 1'b1;
                    ref_next[i] = cfg_reg[i][`PFM_REF_BIT];
                    // guard the pin on low range
                    if ((rng == `PFM_RANGE_LOW_A || rng == `PFM_RANGE_LOW_B)
                            && dac_reg[i] > CLIP_CODE) begin
                        code_next[i*DATA_W +: DATA_W] = DATA_W'(CLIP_CODE);
                    end
                end
                PFM_ADC_SE: begin
                    smp_next[i] = 1'b1;
                end
                PFM_ADC_DIFF: begin
                    smp_next[i] = 1'b1;
                    diff_next[i] = 1'b1;
                    neg_next[i*4 +: 4] = link;
                end
                default: begin
                    drive_next[i] = 1'b0;
                end
            endcase
        end
    end

    // Port controls are registered so every output comes from a flop
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            drive_reg <= '0;
            dig_reg <= '0;
            lvl_reg <= '0;
            ana_reg <= '0;
            smp_reg <= '0;
            diff_reg <= '0;
            ref_reg <= '0;
            range_reg <= '0;
            avg_reg <= '0;
            neg_reg <= '0;
            code_reg <= '0;
        end else if (ce) begin
            drive_reg <= drive_next;
            dig_reg <= dig_next;
            lvl_reg <= lvl_next;
            ana_reg <= ana_next;
            smp_reg <= smp_next;
            diff_reg <= diff_next;
            ref_reg <= ref_next;
            range_reg <= range_next;
            avg_reg <= avg_next;
            neg_reg <= neg_next;
            code_reg <= code_next;
        end
    end

    assign result_rd_data = rd_reg;
    assign port_drive_en = drive_reg;
    assign port_digital = dig_reg;
    assign port_level = lvl_reg;
    assign port_analog = ana_reg;
    assign port_sample = smp_reg;
    assign port_diff = diff_reg;
    assign conversion_reference_select = ref_reg;
    assign port_range = range_reg;
    assign average_count = avg_reg;
    assign port_neg_sel = neg_reg;
    assign port_dac_code = code_reg;

endmodule : pfm_port_mode
